// [include/cpm_regs.svh]
// Register map, key values, reset values and field positions of the clock/power controller.
// Assumes byte addresses on a 32-bit Avalon-MM slave port.
`ifndef CPM_REGS_SVH
`define CPM_REGS_SVH

`define CPM_PWR_KEY1_ADDR   32'hFFFF0404
`define CPM_PWR_CTRL_ADDR   32'hFFFF0408
`define CPM_PWR_KEY2_ADDR   32'hFFFF040C
`define CPM_CLK_KEY1_ADDR   32'hFFFF0410
`define CPM_CLK_CTRL_ADDR   32'hFFFF0414
`define CPM_CLK_KEY2_ADDR   32'hFFFF0418

`define CPM_CLK_KEY1_VAL    16'h00AA
`define CPM_CLK_KEY2_VAL    16'h0055
`define CPM_PWR_KEY1_VAL    16'h0001
`define CPM_PWR_KEY2_VAL    16'h00F4

`define CPM_CLK_RESET       8'h21
`define CPM_PWR_RESET       8'h03
`define CPM_CLK_RD_MASK     8'h23
`define CPM_PWR_RD_MASK     8'h77

`define CPM_REFSEL_BIT      5
`define CPM_CLKMODE_MSB     1
`define CPM_CLKMODE_LSB     0
`define CPM_OPMODE_MSB      6
`define CPM_OPMODE_LSB      4
`define CPM_CPUDIV_MSB      2
`define CPM_CPUDIV_LSB      0

`define CPM_PLL_MULT        11'h4FB

`endif

// [include/cpm_pkg.sv]
// Types shared by the clock/power controller files.
// Assumes cpm_regs.svh supplies all numeric constants.
package cpm_pkg;

	typedef enum logic [2:0] {
		CPM_MODE_NORMAL = 3'h0,
		CPM_MODE_PAUSE  = 3'h1,
		CPM_MODE_NAP    = 3'h2,
		CPM_MODE_SLEEP  = 3'h3,
		CPM_MODE_STOP   = 3'h4
	} cpm_mode_t;

	typedef enum logic [1:0] {
		CPM_CLK_PLL = 2'h1,
		CPM_CLK_EXT = 2'h3
	} cpm_clkmode_t;

	typedef enum logic [2:0] {
		CPM_KS_IDLE   = 3'h1,
		CPM_KS_KEYED  = 3'h2,
		CPM_KS_STAGED = 3'h4
	} cpm_key_state_t;

	typedef struct packed {
		cpm_key_state_t state;
		logic           commit;
	} cpm_seq_t;

	typedef struct packed {
		logic core;
		logic periph;
		logic pll;
		logic xtal;
		logic ext_irq;
	} cpm_domains_t;

endpackage : cpm_pkg

// [core/cpm_clk_div.sv]
// Core clock enable divider: one tick every 2**div_sel system clocks.
// Assumes sys_clk is the PLL clock and div_sel is stable between ticks.
`timescale 1ns/100ps
`default_nettype none
`include "cpm_regs.svh"

module cpm_clk_div #(
	parameter int DIV_W = 3
) (
	input  wire logic             sys_clk,
	input  wire logic             reset,
	input  wire logic             run,
	input  wire logic [DIV_W-1:0] div_sel,
	output logic                  tick
);
	import cpm_pkg::*;

	localparam int CNT_W = (1 << DIV_W) - 1;

	initial begin
		if (DIV_W < 1 || DIV_W > 4) begin
			$error("cpm_clk_div: DIV_W out of range");
		end
	end

	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic             tick_q;
	logic             tick_d;
	logic [CNT_W-1:0] mask;

	////////////////////////////////////////////////////////////////////////
	always_comb begin
		mask   = CNT_W'((64'h1 << div_sel) - 64'h1);
		cnt_d  = run ? CNT_W'(cnt_q + 1'b1) : '0;
		tick_d = run && ((cnt_q & mask) == mask);
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			cnt_q  <= '0;
			tick_q <= 1'b0;
		end else begin
			cnt_q  <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign tick = tick_q;

	////////////////////////////////////////////////////////////////////////
	full_rate_a : assert property (@(posedge sys_clk) disable iff (reset)
		(run && div_sel == '0) ##1 (run && div_sel == '0) |-> tick)
		else $error("full rate divider missed a tick");

endmodule : cpm_clk_div
`default_nettype wire

// [core/cpm_ctrl.sv]
// Clock and power-mode controller with key-protected registers on Avalon-MM.
// Assumes one clock (the PLL clock) and inputs synchronous to it.
`timescale 1ns/100ps
`default_nettype none
`include "cpm_regs.svh"

module cpm_ctrl #(
	parameter int DIV_W = 3
) (
	input  wire logic                sys_clk,
	input  wire logic                reset,
	input  wire logic [31:0]         avs_address,
	input  wire logic                avs_read,
	input  wire logic                avs_write,
	input  wire logic [31:0]         avs_writedata,
	input  wire logic [3:0]          avs_byteenable,
	output logic [31:0]              avs_readdata,
	output logic                     avs_waitrequest,
	input  wire logic                pll_locked,
	input  wire logic [3:0]          external_interrupt,
	input  wire logic                general_timer_two,
	output logic                     reference_select,
	output logic [1:0]               clocking_mode,
	output logic [2:0]               operating_mode_field,
	output logic [DIV_W-1:0]         cpu_divider_field,
	output logic [10:0]              pll_multiplier,
	output cpm_pkg::cpm_domains_t    power_domains,
	output logic                     core_clk_en,
	output logic                     pll_lock_irq
);
	import cpm_pkg::*;

	initial begin
		if (DIV_W != 3) begin
			$error("cpm_ctrl: divider field is three bits wide");
		end
	end

	// Steps a key sequence; out-of-order or wrong-key writes abandon it
	function automatic cpm_seq_t seq_step(cpm_key_state_t s, logic k1, logic k1_ok,
			logic rg, logic k2, logic k2_ok);
		cpm_seq_t r;
		r.state  = s;
		r.commit = 1'b0;
		case (s)
			CPM_KS_IDLE: begin
				if (k1 && k1_ok) r.state = CPM_KS_KEYED;
			end
			CPM_KS_KEYED: begin
				if (rg) r.state = CPM_KS_STAGED;
				else if (k1) r.state = k1_ok ? CPM_KS_KEYED : CPM_KS_IDLE;
				else if (k2) r.state = CPM_KS_IDLE;
			end
			CPM_KS_STAGED: begin
				if (k2) begin
					r.state  = CPM_KS_IDLE;
					r.commit = k2_ok;
				end else if (k1) r.state = k1_ok ? CPM_KS_KEYED : CPM_KS_IDLE;
				else if (rg) r.state = CPM_KS_IDLE;
			end
			default: r.state = CPM_KS_IDLE;
		endcase
		return r;
	endfunction : seq_step

	function automatic logic [31:0] be_mask(logic [31:0] d, logic [3:0] be);
		return d & {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
	endfunction : be_mask

	////////////////////////////////////////////////////////////////////////
	// Bus slave: one wait cycle, then answer
	logic        ack_q;
	logic        ack_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic [31:0] wdata;
	logic        wr_en;
	logic [7:0]  clk_q;
	logic [7:0]  clk_d;
	logic [7:0]  pwr_q;
	logic [7:0]  pwr_d;

	assign avs_waitrequest = (avs_read || avs_write) && !ack_q;
	assign wr_en           = avs_write && !avs_waitrequest;
	assign wdata           = be_mask(avs_writedata, avs_byteenable);

	always_comb begin
		ack_d   = (avs_read || avs_write) && !ack_q;
		rdata_d = rdata_q;
		if (avs_read && !ack_q) begin
			case (avs_address)
				`CPM_CLK_CTRL_ADDR: rdata_d = {24'h000000, clk_q & `CPM_CLK_RD_MASK};
				`CPM_PWR_CTRL_ADDR: rdata_d = {24'h000000, pwr_q & `CPM_PWR_RD_MASK};
				default:            rdata_d = 32'h00000000; // Keys and unmapped read 0
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			ack_q   <= 1'b0;
			rdata_q <= 32'h00000000;
		end else begin
			ack_q   <= ack_d;
			rdata_q <= rdata_d;
		end
	end

	assign avs_readdata = rdata_q;

	////////////////////////////////////////////////////////////////////////
	// Key sequences and protected registers
	cpm_key_state_t cks_q;
	cpm_key_state_t pks_q;
	cpm_seq_t       cseq;
	cpm_seq_t       pseq;
	logic [7:0]     cstage_q;
	logic [7:0]     cstage_d;
	logic [7:0]     pstage_q;
	logic [7:0]     pstage_d;
	logic           wake;
	logic           any_ext;
	cpm_mode_t      mode;

	assign mode    = cpm_mode_t'(pwr_q[`CPM_OPMODE_MSB:`CPM_OPMODE_LSB]);
	assign any_ext = |external_interrupt;

	always_comb begin
		cseq = seq_step(cks_q,
			wr_en && avs_address == `CPM_CLK_KEY1_ADDR, wdata[15:0] == `CPM_CLK_KEY1_VAL,
			wr_en && avs_address == `CPM_CLK_CTRL_ADDR,
			wr_en && avs_address == `CPM_CLK_KEY2_ADDR, wdata[15:0] == `CPM_CLK_KEY2_VAL);
		pseq = seq_step(pks_q,
			wr_en && avs_address == `CPM_PWR_KEY1_ADDR, wdata[15:0] == `CPM_PWR_KEY1_VAL,
			wr_en && avs_address == `CPM_PWR_CTRL_ADDR,
			wr_en && avs_address == `CPM_PWR_KEY2_ADDR, wdata[15:0] == `CPM_PWR_KEY2_VAL);
		cstage_d = (cks_q == CPM_KS_KEYED && wr_en && avs_address == `CPM_CLK_CTRL_ADDR)
			? wdata[7:0] : cstage_q;
		pstage_d = (pks_q == CPM_KS_KEYED && wr_en && avs_address == `CPM_PWR_CTRL_ADDR)
			? wdata[7:0] : pstage_q;
		// Stop keeps only external interrupts alive, so the timer cannot wake it
		case (mode)
			CPM_MODE_PAUSE, CPM_MODE_NAP,
			CPM_MODE_SLEEP: wake = any_ext || general_timer_two;
			CPM_MODE_STOP:  wake = any_ext;
			default:        wake = 1'b0;
		endcase
		clk_d = cseq.commit ? (cstage_q & `CPM_CLK_RD_MASK) : clk_q;
		pwr_d = pwr_q;
		// A fresh software commit outranks a wake in the same cycle
		if (pseq.commit) begin
			pwr_d = pstage_q & `CPM_PWR_RD_MASK;
		end else if (wake) begin
			pwr_d[`CPM_OPMODE_MSB:`CPM_OPMODE_LSB] = CPM_MODE_NORMAL;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			cks_q    <= CPM_KS_IDLE;
			pks_q    <= CPM_KS_IDLE;
			cstage_q <= 8'h00;
			pstage_q <= 8'h00;
			clk_q    <= `CPM_CLK_RESET;
			pwr_q    <= `CPM_PWR_RESET;
		end else begin
			cks_q    <= cseq.state;
			pks_q    <= pseq.state;
			cstage_q <= cstage_d;
			pstage_q <= pstage_d;
			clk_q    <= clk_d;
			pwr_q    <= pwr_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Power domains, lock supervision and core clock
	cpm_domains_t dom_q;
	cpm_domains_t dom_d;
	logic         lock_irq_q;
	logic         lock_irq_d;
	logic         lock_ok;
	logic         div_tick;

	// External clock mode does not depend on the PLL lock
	assign lock_ok = pll_locked || clk_q[`CPM_CLKMODE_MSB:`CPM_CLKMODE_LSB] == CPM_CLK_EXT;

	always_comb begin
		dom_d         = '0;
		dom_d.ext_irq = 1'b1;
		dom_d.xtal    = mode != CPM_MODE_STOP;
		dom_d.pll     = dom_d.xtal && mode != CPM_MODE_SLEEP;
		dom_d.periph  = dom_d.pll && mode != CPM_MODE_NAP;
		dom_d.core    = dom_d.periph && mode != CPM_MODE_PAUSE;
		lock_irq_d    = !lock_ok && dom_d.pll;
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			dom_q      <= '0;
			lock_irq_q <= 1'b0;
		end else begin
			dom_q      <= dom_d;
			lock_irq_q <= lock_irq_d;
		end
	end

	cpm_clk_div #(
		.DIV_W (DIV_W)
	) u_div (
		.sys_clk (sys_clk),
		.reset   (reset),
		.run     (dom_q.core),
		.div_sel (pwr_q[`CPM_CPUDIV_MSB:`CPM_CPUDIV_LSB]),
		.tick    (div_tick)
	);

	// Gated without a register so a lock loss halts the core at once
	assign core_clk_en          = div_tick && lock_ok;
	assign pll_lock_irq         = lock_irq_q;
	assign power_domains        = dom_q;
	assign reference_select     = clk_q[`CPM_REFSEL_BIT];
	assign clocking_mode        = clk_q[`CPM_CLKMODE_MSB:`CPM_CLKMODE_LSB];
	assign operating_mode_field = pwr_q[`CPM_OPMODE_MSB:`CPM_OPMODE_LSB];
	assign cpu_divider_field    = pwr_q[`CPM_CPUDIV_MSB:`CPM_CPUDIV_LSB];
	assign pll_multiplier       = `CPM_PLL_MULT;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	key_commit_a : assert property (
		(pks_q == CPM_KS_STAGED && wr_en && avs_address == `CPM_PWR_KEY2_ADDR
		 && wdata[15:0] == `CPM_PWR_KEY2_VAL)
		|=> pwr_q == ($past(pstage_q) & `CPM_PWR_RD_MASK))
		else $error("power write not committed after second key");
	clk_guard_a : assert property (
		!(cks_q == CPM_KS_STAGED && wr_en && avs_address == `CPM_CLK_KEY2_ADDR) |=> $stable(clk_q))
		else $error("clock config changed without key sequence");
	idle_write_a : assert property (
		(pks_q == CPM_KS_IDLE && wr_en && avs_address == `CPM_PWR_CTRL_ADDR) |=> pks_q == CPM_KS_IDLE)
		else $error("unkeyed power write was staged");
	ref_select_a : assert property (
		reference_select == clk_q[`CPM_REFSEL_BIT] && clk_q[7:6] == 2'h0 && clk_q[4:2] == 3'h0)
		else $error("reference select or reserved bits wrong");
	readback_a : assert property (
		(avs_read && !ack_q && avs_address == `CPM_CLK_CTRL_ADDR)
		|=> !avs_waitrequest && avs_readdata == {24'h000000, $past(clk_q)})
		else $error("clock config readback wrong");
	sleep_wake_a : assert property (
		(mode == CPM_MODE_SLEEP && (any_ext || general_timer_two) && !pseq.commit)
		|=> operating_mode_field == CPM_MODE_NORMAL)
		else $error("sleep did not wake");
	domain_map_a : assert property (
		(mode == CPM_MODE_NAP && !wake && !pseq.commit) |=> ##1
		(!power_domains.core && !power_domains.periph && power_domains.pll))
		else $error("nap domains wrong");
	lock_halt_a : assert property (
		(!lock_ok) |-> !core_clk_en ##1 (pll_lock_irq || !dom_q.pll || lock_ok))
		else $error("core ran without lock");
	wait_once_a : assert property (
		(avs_write && avs_waitrequest) |=> !avs_waitrequest)
		else $error("waitrequest held more than one cycle");
	mult_const_a : assert property (
		pll_multiplier == 11'd1275)
		else $error("pll multiplier wrong");

	cover_pwr_seq_c : cover property (pks_q == CPM_KS_STAGED ##1 pks_q == CPM_KS_IDLE);
	cover_wake_c    : cover property (mode == CPM_MODE_SLEEP ##1 mode == CPM_MODE_NORMAL);
	cover_ext_clk_c : cover property (clocking_mode == CPM_CLK_EXT);
	cover_lock_c    : cover property (pll_lock_irq ##[1:20] !pll_lock_irq);

endmodule : cpm_ctrl
`default_nettype wire

// [test/cpm_ctrl_tb.sv]
// Self-checking bench for the clock/power controller, driven over its Avalon-MM port.
// Assumes cpm_pkg and cpm_regs.svh are compiled and on the include path.
`timescale 1ns/100ps
`default_nettype none
`include "cpm_regs.svh"

module cpm_ctrl_tb;
	import cpm_pkg::*;

	logic               sys_clk;
	logic               reset;
	logic [31:0]        avs_address;
	logic               avs_read;
	logic               avs_write;
	logic [31:0]        avs_writedata;
	logic [3:0]         avs_byteenable;
	logic [31:0]        avs_readdata;
	logic               avs_waitrequest;
	logic               pll_locked;
	logic [3:0]         external_interrupt;
	logic               general_timer_two;
	logic               reference_select;
	logic [1:0]         clocking_mode;
	logic [2:0]         operating_mode_field;
	logic [2:0]         cpu_divider_field;
	logic [10:0]        pll_multiplier;
	cpm_domains_t       power_domains;
	logic               core_clk_en;
	logic               pll_lock_irq;
	int                 err_count;
	int                 n_tests;
	logic [31:0]        d;
	int                 c;
	logic [31:0]        bad [3][3];
	logic [4:0]         dom [5];

	cpm_ctrl #(.DIV_W(3)) dut_u (
		.sys_clk(sys_clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .pll_locked(pll_locked),
		.external_interrupt(external_interrupt), .general_timer_two(general_timer_two),
		.reference_select(reference_select), .clocking_mode(clocking_mode),
		.operating_mode_field(operating_mode_field), .cpu_divider_field(cpu_divider_field),
		.pll_multiplier(pll_multiplier), .power_domains(power_domains),
		.core_clk_en(core_clk_en), .pll_lock_irq(pll_lock_irq)
	);

	always #20 sys_clk = ~sys_clk;

	////////////////////////////////////////////////////////////////////////////
	task automatic wrap_up();
		$display("compares %0d mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
		end
	endtask : chk

	// Request stands until the rising edge that samples waitrequest low
	task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
			output logic [31:0] rdat);
		int n;
		n = 0;
		@(posedge sys_clk);
		avs_address <= a;
		avs_writedata <= wd;
		avs_write <= wr;
		avs_read <= !wr;
		do begin
			@(posedge sys_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		if (n >= 20) begin
			err_count++;
			$display("[FAIL] %0t bus never answered", $time);
			wrap_up();
		end
		rdat = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		// Outputs updated at the taking edge settle before callers look
		@(negedge sys_clk);
	endtask : xfer

	task automatic wr(input logic [31:0] a, input logic [31:0] wd);
		logic [31:0] x;
		xfer(1'b1, a, wd, x);
	endtask : wr

	task automatic rd(input logic [31:0] a, output logic [31:0] rdat);
		xfer(1'b0, a, 32'h0, rdat);
	endtask : rd

	task automatic clk_seq(input logic [31:0] k1, input logic [31:0] v, input logic [31:0] k2);
		wr(`CPM_CLK_KEY1_ADDR, k1);
		wr(`CPM_CLK_CTRL_ADDR, v);
		wr(`CPM_CLK_KEY2_ADDR, k2);
	endtask : clk_seq

	task automatic pwr_seq(input logic [31:0] v);
		wr(`CPM_PWR_KEY1_ADDR, 32'h01);
		wr(`CPM_PWR_CTRL_ADDR, v);
		wr(`CPM_PWR_KEY2_ADDR, 32'hF4);
	endtask : pwr_seq

	task automatic count_ticks(input int n, output int cnt);
		cnt = 0;
		repeat (n) begin
			@(negedge sys_clk);
			if (core_clk_en === 1'b1) cnt++;
		end
	endtask : count_ticks

	////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (50000) @(posedge sys_clk);
		err_count++;
		$display("[FAIL] %0t run took too long", $time);
		wrap_up();
	end

	initial begin
		sys_clk = 1'b0;
		reset = 1'b1;
		avs_address = 32'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hF;
		pll_locked = 1'b1;
		external_interrupt = 4'h0;
		general_timer_two = 1'b0;
		err_count = 0;
		n_tests = 0;
		bad = '{'{32'hAB, 32'h00, 32'h55}, '{32'hAA, 32'h00, 32'h56}, '{32'h01, 32'h00, 32'hF4}};
		dom = '{5'h1F, 5'h0F, 5'h07, 5'h03, 5'h01};
		repeat (8) @(posedge sys_clk);
		reset <= 1'b0;
		// Reset state
		rd(`CPM_CLK_CTRL_ADDR, d);
		chk(d, 32'h21, "clock config reset");
		rd(`CPM_PWR_CTRL_ADDR, d);
		chk(d, 32'h03, "power reset");
		rd(`CPM_CLK_KEY1_ADDR, d);
		chk(d, 32'h0, "key reads zero");
		chk({21'h0, pll_multiplier}, 32'd1275, "multiplier");
		$display("reset test done");
		// Unkeyed and miskeyed writes
		wr(`CPM_CLK_CTRL_ADDR, 32'h00);
		for (int i = 0; i < 3; i++) clk_seq(bad[i][0], bad[i][1], bad[i][2]);
		rd(`CPM_CLK_CTRL_ADDR, d);
		chk(d, 32'h21, "clock config kept");
		wr(`CPM_PWR_CTRL_ADDR, 32'h20);
		wr(`CPM_PWR_KEY1_ADDR, 32'h01);
		wr(`CPM_PWR_CTRL_ADDR, 32'h40);
		wr(`CPM_PWR_KEY2_ADDR, 32'h55);
		rd(`CPM_PWR_CTRL_ADDR, d);
		chk(d, 32'h03, "power kept");
		$display("key guard test done");
		// Clock source fields
		clk_seq(32'hAA, 32'hFF, 32'h55);
		rd(`CPM_CLK_CTRL_ADDR, d);
		chk(d, 32'h23, "clock config external");
		chk({30'h0, clocking_mode}, 32'h3, "clocking mode");
		clk_seq(32'hAA, 32'h01, 32'h55);
		chk({31'h0, reference_select}, 32'h0, "crystal reference");
		clk_seq(32'hAA, 32'h21, 32'h55);
		chk({31'h0, reference_select}, 32'h1, "internal reference");
		$display("clock source test done");
		// Every operating mode and its domains
		for (int m = 0; m < 5; m++) begin
			pwr_seq((m << 4) | 3);
			repeat (2) @(posedge sys_clk);
			@(negedge sys_clk);
			chk({29'h0, operating_mode_field}, m, "mode field");
			chk({27'h0, power_domains}, {27'h0, dom[m]}, "domains");
		end
		$display("mode test done");
		// Wake from sleep by each source
		for (int i = 0; i < 5; i++) begin
			pwr_seq(32'h33);
			@(negedge sys_clk);
			chk({29'h0, operating_mode_field}, 32'h3, "asleep");
			@(posedge sys_clk);
			if (i < 4) external_interrupt <= 4'h1 << i;
			else general_timer_two <= 1'b1;
			@(posedge sys_clk);
			@(negedge sys_clk);
			chk({29'h0, operating_mode_field}, 32'h0, "woken");
			@(posedge sys_clk);
			external_interrupt <= 4'h0;
			general_timer_two <= 1'b0;
		end
		$display("wake test done");
		// Divider rate, whole periods counted
		for (int cd = 0; cd < 8; cd++) begin
			pwr_seq(cd);
			chk({29'h0, cpu_divider_field}, cd, "divider field");
			repeat (130) @(posedge sys_clk);
			count_ticks(4 << cd, c);
			chk(c, 32'd4, "core ticks");
		end
		$display("divider test done");
		// Lock loss halts core in PLL mode only
		pwr_seq(32'h00);
		@(posedge sys_clk);
		pll_locked <= 1'b0;
		repeat (3) @(posedge sys_clk);
		count_ticks(16, c);
		chk(c, 32'd0, "halted while unlocked");
		chk({31'h0, pll_lock_irq}, 32'h1, "lock irq");
		clk_seq(32'hAA, 32'h03, 32'h55);
		count_ticks(16, c);
		chk(c, 32'd16, "external clock ignores lock");
		chk({31'h0, pll_lock_irq}, 32'h0, "no irq off PLL");
		clk_seq(32'hAA, 32'h21, 32'h55);
		@(posedge sys_clk);
		pll_locked <= 1'b1;
		repeat (3) @(posedge sys_clk);
		count_ticks(16, c);
		chk(c, 32'd16, "resumed on relock");
		chk({31'h0, pll_lock_irq}, 32'h0, "irq gone");
		$display("lock test done");
		wrap_up();
	end

endmodule : cpm_ctrl_tb
`default_nettype wire
